// File: hw/epod_top.sv
// Purpose: Scales the motor encoder edge stream by numerator/denominator and re-drives it as quadrature.
// Assumes: aclk 20 MHz, aresetn synchronous active low, servo_on and enc_ppr from same-clock logic.
// Notes: Registers over AXI4-Lite; encoder pins pass two flip-flops before decoding.
// Behaviour
// - Output count equals input times num/den, or equals input when num exceeds den.
// - Numerator is 32-bit, range one to 8388808.
// - Denominator same range, never zero.
// - Never more output pulses than input pulses.
// - Select zero: A leads B forward.
// - Select one: B leads A forward.
// - Direction select byte accepts zero or one.
// - Auto setup loads both with encoder count.
// - Two channels A, B, complementary pairs.
`include "epod_params.svh"
module epod_top #(
  parameter int RATIO_W = 24
) (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write channels.
  input wire logic [15:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read channels.
  input wire logic [15:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Drive state and attached encoder.
  input wire logic servo_on,
  input wire logic [31:0] enc_ppr,
  input wire logic enc_a_in,
  input wire logic enc_b_in,
  // Quadrature line-driver outputs.
  output epod_pkg::epod_diff_t quad_out_phase_a_pair,
  output epod_pkg::epod_diff_t quad_out_phase_b_pair
);
  import epod_pkg::*;

  if (RATIO_W < 24 || RATIO_W > 31) begin : g_chk
    $error("RATIO_W must be between 24 and 31");
  end

  logic [7:0] output_direction_select;
  logic [31:0] ratio_numerator;
  logic [31:0] ratio_denominator;
  logic [31:0] out_count;
  logic [RATIO_W:0] acc;
  logic a_s1, a_s2, a_s3, b_s1, b_s2, b_s3;
  logic in_step, in_fwd, out_step, out_fwd;
  logic [1:0] phase;
  logic [RATIO_W:0] eff_num, next_acc;
  logic aw_got, w_got;
  logic [15:0] aw_idx;
  logic [31:0] w_val;
  logic [3:0] w_be;
  logic [31:0] merged;
  logic wr_fire, wr_ok, ratio_wr, setup_ok;
  epod_wstate_t wstate;

  // Encoder pins are asynchronous; the first stage feeds only the second.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      a_s1 <= 1'b0;
      a_s2 <= 1'b0;
      a_s3 <= 1'b0;
      b_s1 <= 1'b0;
      b_s2 <= 1'b0;
      b_s3 <= 1'b0;
    end else begin
      a_s1 <= enc_a_in;
      a_s2 <= a_s1;
      a_s3 <= a_s2;
      b_s1 <= enc_b_in;
      b_s2 <= b_s1;
      b_s3 <= b_s2;
    end
  end

  // One legal edge of either channel is one encoder count; a double change is dropped.
  assign in_step = (a_s2 ^ a_s3) ^ (b_s2 ^ b_s3);
  assign in_fwd = a_s2 ^ b_s3;

  // A numerator above the denominator is clamped to a ratio of one.
  assign eff_num = (ratio_numerator > ratio_denominator) ? ratio_denominator[RATIO_W:0] :
    ratio_numerator[RATIO_W:0];
  assign next_acc = acc + eff_num;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      acc <= '0;
      out_step <= 1'b0;
      out_fwd <= 1'b0;
    end else begin
      out_step <= 1'b0;
      if (ratio_wr) begin
        acc <= '0;
      end else if (in_step) begin
        out_fwd <= in_fwd;
        if (next_acc >= ratio_denominator[RATIO_W:0]) begin
          acc <= next_acc - ratio_denominator[RATIO_W:0];
          out_step <= 1'b1;
        end else begin
          acc <= next_acc;
        end
      end
    end
  end

  // Phase counts up for forward motion; mapping below makes A lead B when select bit 0 is clear, B lead A when set.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phase <= 2'h0;
      out_count <= 32'h0000_0000;
    end else if (out_step) begin
      phase <= out_fwd ? phase + 2'h1 : phase - 2'h1;
      out_count <= out_count + 32'h0000_0001;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      quad_out_phase_a_pair <= '{pos: 1'b0, neg: 1'b1};
      quad_out_phase_b_pair <= '{pos: 1'b0, neg: 1'b1};
    end else if (output_direction_select[0]) begin
      quad_out_phase_a_pair <= '{pos: phase[1], neg: ~phase[1]};
      quad_out_phase_b_pair <= '{pos: phase[1] ^ phase[0], neg: ~(phase[1] ^ phase[0])};
    end else begin
      quad_out_phase_a_pair <= '{pos: phase[1] ^ phase[0], neg: ~(phase[1] ^ phase[0])};
      quad_out_phase_b_pair <= '{pos: phase[1], neg: ~phase[1]};
    end
  end

  // Write address and data are latched independently, then applied together.
  assign awready = !aw_got && wstate == EPOD_W_IDLE;
  assign wready = !w_got && wstate == EPOD_W_IDLE;
  assign wr_fire = aw_got && w_got && wstate == EPOD_W_IDLE;

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      merged[i*8 +: 8] = w_be[i] ? w_val[i*8 +: 8] : 8'h00;
    end
  end

  always_comb begin
    wr_ok = 1'b0;
    ratio_wr = 1'b0;
    setup_ok = 1'b0;
    if (wr_fire && !servo_on) begin
      case (aw_idx)
        `EPOD_IDX_DIR: wr_ok = merged <= 32'h0000_0001;
        `EPOD_IDX_NUM, `EPOD_IDX_DEN: begin
          wr_ok = merged >= `EPOD_RATIO_MIN && merged <= `EPOD_RATIO_MAX;
          ratio_wr = wr_ok;
        end
        `EPOD_IDX_SETUP: begin
          setup_ok = merged[`EPOD_SETUP_GO] && enc_ppr >= `EPOD_RATIO_MIN && enc_ppr <= `EPOD_RATIO_MAX;
          wr_ok = setup_ok || !merged[`EPOD_SETUP_GO];
          ratio_wr = setup_ok;
        end
        default: wr_ok = 1'b0;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_idx <= 16'h0000;
      w_val <= 32'h0000_0000;
      w_be <= 4'h0;
    end else begin
      if (awvalid && awready) begin
        aw_got <= 1'b1;
        aw_idx <= {2'h0, awaddr[15:2]};
      end else if (wr_fire) begin
        aw_got <= 1'b0;
      end
      if (wvalid && wready) begin
        w_got <= 1'b1;
        w_val <= wdata;
        w_be <= wstrb;
      end else if (wr_fire) begin
        w_got <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wstate <= EPOD_W_IDLE;
      bvalid <= 1'b0;
      bresp <= EPOD_RESP_OKAY;
    end else begin
      case (wstate)
        EPOD_W_IDLE: begin
          if (wr_fire) begin
            wstate <= EPOD_W_RESP;
            bvalid <= 1'b1;
            bresp <= wr_ok ? EPOD_RESP_OKAY : EPOD_RESP_SLVERR;
          end
        end
        EPOD_W_RESP: begin
          if (bready) begin
            wstate <= EPOD_W_IDLE;
            bvalid <= 1'b0;
          end
        end
        default: begin
          wstate <= EPOD_W_IDLE;
          bvalid <= 1'b0;
        end
      endcase
    end
  end

  // Settings are accepted only while the servo is off and the value is in range.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      output_direction_select <= `EPOD_RST_DIR;
      ratio_numerator <= `EPOD_RST_RATIO;
      ratio_denominator <= `EPOD_RST_RATIO;
    end else if (wr_ok) begin
      if (setup_ok) begin
        ratio_numerator <= enc_ppr;
        ratio_denominator <= enc_ppr;
      end else if (aw_idx == `EPOD_IDX_DIR) begin
        output_direction_select <= merged[7:0];
      end else if (aw_idx == `EPOD_IDX_NUM) begin
        ratio_numerator <= merged;
      end else if (aw_idx == `EPOD_IDX_DEN) begin
        ratio_denominator <= merged;
      end
    end
  end

  assign arready = !rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= EPOD_RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rresp <= EPOD_RESP_OKAY;
      case ({2'h0, araddr[15:2]})
        `EPOD_IDX_DIR: rdata <= {24'h00_0000, output_direction_select};
        `EPOD_IDX_NUM: rdata <= ratio_numerator;
        `EPOD_IDX_DEN: rdata <= ratio_denominator;
        `EPOD_IDX_SETUP: rdata <= 32'h0000_0000;
        `EPOD_IDX_STATUS: rdata <= {30'h0000_0000, ratio_numerator > ratio_denominator, servo_on};
        `EPOD_IDX_COUNT: rdata <= out_count;
        default: begin
          rdata <= 32'h0000_0000;
          rresp <= EPOD_RESP_SLVERR;
        end
      endcase
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_RATIO_STEP: assert property (in_step && !ratio_wr && next_acc >= ratio_denominator[RATIO_W:0] |=> out_step)
    else $error("output step missing when accumulator wraps");
  AST_NUM_RANGE: assert property (ratio_numerator >= `EPOD_RATIO_MIN && ratio_numerator <= `EPOD_RATIO_MAX)
    else $error("numerator out of range");
  AST_DEN_RANGE: assert property (ratio_denominator >= `EPOD_RATIO_MIN && ratio_denominator <= `EPOD_RATIO_MAX)
    else $error("denominator out of range");
  AST_NO_MULTIPLY: assert property (out_step |-> $past(in_step) && !$past(ratio_wr))
    else $error("output step without input step");
  AST_A_LEADS: assert property (out_step && out_fwd && output_direction_select == 8'h00 |-> ##2
    (quad_out_phase_a_pair.pos != $past(quad_out_phase_a_pair.pos)) ==
    ($past(quad_out_phase_a_pair.pos) == $past(quad_out_phase_b_pair.pos)))
    else $error("A does not lead B in forward");
  AST_B_LEADS: assert property (out_step && out_fwd && output_direction_select == 8'h01 |-> ##2
    (quad_out_phase_b_pair.pos != $past(quad_out_phase_b_pair.pos)) ==
    ($past(quad_out_phase_a_pair.pos) == $past(quad_out_phase_b_pair.pos)))
    else $error("B does not lead A in forward");
  AST_SEL_RANGE: assert property (output_direction_select <= 8'h01)
    else $error("direction select out of range");
  AST_SETUP_LOAD: assert property (setup_ok |=> ratio_numerator == $past(enc_ppr) &&
    ratio_denominator == $past(enc_ppr))
    else $error("auto setup did not load ratio");
  AST_DIFF_PAIR: assert property (quad_out_phase_a_pair.neg == !quad_out_phase_a_pair.pos &&
    quad_out_phase_b_pair.neg == !quad_out_phase_b_pair.pos)
    else $error("line pair not complementary");
  AST_ACC_BOUND: assert property (acc < ratio_denominator[RATIO_W:0])
    else $error("accumulator not below denominator");

  COV_FWD_STEP: cover property (out_step && out_fwd);
  COV_REV_STEP: cover property (out_step && !out_fwd);
  COV_SETUP: cover property (setup_ok);
  COV_CLAMP: cover property (in_step && ratio_numerator > ratio_denominator);
endmodule : epod_top

// File: hw/epod_params.svh
// Purpose: Offsets, reset values and limits of the encoder pulse output divider.
// Assumes: Register indices are word indices; the byte address is four times the index.
// Notes: Included by the divider module and by its bench.
`ifndef EPOD_PARAMS_SVH
`define EPOD_PARAMS_SVH
`define EPOD_IDX_DIR 16'h2300
`define EPOD_IDX_NUM 16'h230B
`define EPOD_IDX_DEN 16'h230C
`define EPOD_IDX_SETUP 16'h2310
`define EPOD_IDX_STATUS 16'h2311
`define EPOD_IDX_COUNT 16'h2312
`define EPOD_RST_DIR 8'h00
`define EPOD_RST_RATIO 32'h0000_0001
`define EPOD_RATIO_MIN 32'h0000_0001
`define EPOD_RATIO_MAX 32'h0080_00C8
`define EPOD_SETUP_GO 0
`define EPOD_ST_SERVO_ON 0
`define EPOD_ST_CLAMPED 1
`endif

// File: hw/epod_pkg.sv
// Purpose: Types shared by the encoder pulse output divider.
// Assumes: Nothing beyond SystemVerilog packages.
// Notes: AXI response codes and the differential pair carrier live here.
package epod_pkg;
  typedef enum logic [1:0] {
    EPOD_RESP_OKAY = 2'h0,
    EPOD_RESP_SLVERR = 2'h2
  } epod_resp_t;
  typedef struct packed {
    logic pos;
    logic neg;
  } epod_diff_t;
  typedef enum logic [1:0] {
    EPOD_W_IDLE = 2'h1,
    EPOD_W_RESP = 2'h2
  } epod_wstate_t;
endpackage : epod_pkg

// File: dv/epod_host_model.sv
// Purpose: Quadrature counter standing in for the host controller behind the line drivers.
// Assumes: Line pairs are sampled on aclk and change at most one phase per cycle.
// Notes: Counts up when A leads B; anything illegal on the pairs is counted as a fault.
module epod_host_model (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Line pairs from the divider.
  input wire epod_pkg::epod_diff_t line_a,
  input wire epod_pkg::epod_diff_t line_b,
  // Counter state for the bench.
  output int position,
  output int n_fault
);
  timeunit 1ns;
  timeprecision 1ns;
  import epod_pkg::*;
  logic [1:0] prev;
  logic [1:0] now;
  logic bad_pair;
  assign now = {line_a.pos, line_b.pos};
  assign bad_pair = (line_a.neg !== ~line_a.pos) || (line_b.neg !== ~line_b.pos);

  // One forward step of the Gray sequence 00, 10, 11, 01.
  function automatic logic [1:0] fwd(input logic [1:0] v);
    return (v[1] == v[0]) ? {~v[1], v[0]} : {v[1], ~v[0]};
  endfunction : fwd

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev <= 2'h0;
      position <= 0;
      n_fault <= 0;
    end else begin
      prev <= now;
      if (now != prev && now == fwd(prev)) begin
        position <= position + 1;
      end else if (now != prev && prev == fwd(now)) begin
        position <= position - 1;
      end
      if (bad_pair || (now != prev && now != fwd(prev) && prev != fwd(now))) begin
        n_fault <= n_fault + 1;
      end
    end
  end
endmodule : epod_host_model

// File: dv/test_encoder_pulse_output_divider.sv
// Purpose: Self-checking bench for the encoder pulse output divider.
// Assumes: Registers over AXI4-Lite at byte address four times the index.
// Notes: Encoder pins step every four cycles, well inside the sampling limit.
`include "epod_params.svh"
`define CHK(what, exp, got) \
  begin \
    compares++; \
    if ((got) !== (exp)) begin \
      n_mismatch++; \
      $display("unexpected %s expected %0h seen %0h", what, exp, got); \
    end \
  end
module test_encoder_pulse_output_divider;
  timeunit 1ns;
  timeprecision 1ns;
  import epod_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [15:0] awaddr = 16'h0000, araddr = 16'h0000;
  logic [31:0] wdata = 32'h0000_0000, enc_ppr = 32'h0000_0000, rdata;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic servo_on = 1'b0, enc_a = 1'b0, enc_b = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  epod_diff_t pair_a, pair_b;
  int position, n_fault, base;
  int n_mismatch = 0;
  int compares = 0;

  always #25 aclk = ~aclk;

  epod_top i_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .servo_on(servo_on), .enc_ppr(enc_ppr), .enc_a_in(enc_a),
    .enc_b_in(enc_b), .quad_out_phase_a_pair(pair_a), .quad_out_phase_b_pair(pair_b));

  epod_host_model i_host (.aclk(aclk), .aresetn(aresetn), .line_a(pair_a), .line_b(pair_b),
    .position(position), .n_fault(n_fault));

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : summarize

  task automatic wr(input logic [15:0] idx, input logic [31:0] d, input logic [1:0] exp, input string what);
    logic [1:0] r;
    bit aw, w, got;
    aw = 0;
    w = 0;
    got = 0;
    r = 2'h1;
    @(posedge aclk);
    awaddr <= idx << 2;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int t = 0; t < 100 && !got; t++) begin
      @(posedge aclk);
      if (!aw && awready) begin
        aw = 1;
        awvalid <= 1'b0;
      end
      if (!w && wready) begin
        w = 1;
        wvalid <= 1'b0;
      end
      if (aw && w && bvalid) begin
        got = 1;
        r = bresp;
        bready <= 1'b0;
      end
    end
    `CHK(what, exp, r)
  endtask : wr

  task automatic rd(input logic [15:0] idx, input logic [31:0] exp_d, input logic [1:0] exp, input string what);
    logic [31:0] d;
    logic [1:0] r;
    bit got;
    got = 0;
    d = 32'hDEAD_BEEF;
    r = 2'h1;
    @(posedge aclk);
    araddr <= idx << 2;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int t = 0; t < 100 && !got; t++) begin
      @(posedge aclk);
      if (arready) begin
        arvalid <= 1'b0;
      end
      if (rvalid) begin
        got = 1;
        d = rdata;
        r = rresp;
        rready <= 1'b0;
      end
    end
    `CHK(what, exp, r)
    `CHK(what, exp_d, d)
  endtask : rd

  // Steps the encoder forward n counts and checks the host's change of position.
  task automatic move(input int n, input int exp_delta, input string what);
    base = position;
    repeat (n) begin
      @(posedge aclk);
      if (enc_a == enc_b) enc_a <= ~enc_a;
      else enc_b <= ~enc_b;
      repeat (3) @(posedge aclk);
    end
    repeat (8) @(posedge aclk);
    `CHK(what, exp_delta, position - base)
    $display("test %s done", what);
  endtask : move

  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`EPOD_IDX_DIR, 32'h0, EPOD_RESP_OKAY, "dir reset");
    rd(`EPOD_IDX_NUM, 32'h1, EPOD_RESP_OKAY, "num reset");
    rd(`EPOD_IDX_DEN, 32'h1, EPOD_RESP_OKAY, "den reset");
    rd(16'h2305, 32'h0, EPOD_RESP_SLVERR, "unmapped read");
    wr(`EPOD_IDX_NUM, 32'h0, EPOD_RESP_SLVERR, "num zero");
    wr(`EPOD_IDX_NUM, 32'h0080_00C9, EPOD_RESP_SLVERR, "num above max");
    wr(`EPOD_IDX_DEN, 32'h0, EPOD_RESP_SLVERR, "den zero");
    wr(`EPOD_IDX_DIR, 32'h2, EPOD_RESP_SLVERR, "dir two");
    servo_on <= 1'b1;
    wr(`EPOD_IDX_NUM, 32'h2, EPOD_RESP_SLVERR, "num servo on");
    rd(`EPOD_IDX_STATUS, 32'h0000_0001, EPOD_RESP_OKAY, "status servo on");
    servo_on <= 1'b0;
    rd(`EPOD_IDX_NUM, 32'h1, EPOD_RESP_OKAY, "num kept");
    $display("test refusals done");
    wr(`EPOD_IDX_NUM, 32'h0080_00C8, EPOD_RESP_OKAY, "num max");
    wr(`EPOD_IDX_DEN, 32'h0080_00C8, EPOD_RESP_OKAY, "den max");
    rd(`EPOD_IDX_DEN, 32'h0080_00C8, EPOD_RESP_OKAY, "den max read");
    move(8, 8, "forward a leads");
    wr(`EPOD_IDX_DIR, 32'h1, EPOD_RESP_OKAY, "dir one");
    move(8, -8, "forward b leads");
    wr(`EPOD_IDX_DIR, 32'h0, EPOD_RESP_OKAY, "dir zero");
    wr(`EPOD_IDX_NUM, 32'h1, EPOD_RESP_OKAY, "num one");
    wr(`EPOD_IDX_DEN, 32'h3, EPOD_RESP_OKAY, "den three");
    move(12, 4, "divide by three");
    wr(`EPOD_IDX_NUM, 32'h5, EPOD_RESP_OKAY, "num five");
    rd(`EPOD_IDX_STATUS, 32'h0000_0002, EPOD_RESP_OKAY, "status clamped");
    wr(`EPOD_IDX_DEN, 32'h1, EPOD_RESP_OKAY, "den one");
    move(4, 4, "no multiply");
    wr(`EPOD_IDX_COUNT, 32'h0, EPOD_RESP_SLVERR, "count read only");
    rd(`EPOD_IDX_COUNT, 32'h0000_0018, EPOD_RESP_OKAY, "output edge count");
    wr(`EPOD_IDX_SETUP, 32'h1, EPOD_RESP_SLVERR, "setup no encoder");
    enc_ppr <= 32'h0000_03E8;
    wr(`EPOD_IDX_SETUP, 32'h1, EPOD_RESP_OKAY, "auto setup");
    rd(`EPOD_IDX_NUM, 32'h0000_03E8, EPOD_RESP_OKAY, "num auto");
    rd(`EPOD_IDX_DEN, 32'h0000_03E8, EPOD_RESP_OKAY, "den auto");
    $display("test auto setup done");
    `CHK("pair faults", 0, n_fault)
    summarize();
  end

  initial begin
    repeat (20000) @(posedge aclk);
    n_mismatch++;
    summarize();
  end
endmodule : test_encoder_pulse_output_divider
